// [rtl/ida_map.svh]
`ifndef IDA_MAP_SVH
`define IDA_MAP_SVH

// Register offsets
`define IDA_OFF_WIN_A 8'h00
`define IDA_OFF_PTR_A 8'h01
`define IDA_OFF_WIN_B 8'h02
`define IDA_OFF_PTR_B 8'h03
`define IDA_OFF_BANK 8'h04
// Memory-control register, mapped only in one bank
`define IDA_OFF_MEM_CTRL 8'h40
`define IDA_MEM_CTRL_BANK 8'h01
// General purpose area: address bit 7 set
`define IDA_GPR_BIT 7
`define IDA_BANK_SIZE 128
// Reset values
`define IDA_PTR_RST 8'h00
`define IDA_BANK_RST 8'h00
`define IDA_NULL_READ 8'h00

`endif

// [rtl/ida_pkg.sv]
package ida_pkg;

  typedef enum logic [2:0] {
    IDA_TGT_NONE = 3'b000,
    IDA_TGT_PTR_A = 3'b001,
    IDA_TGT_PTR_B = 3'b010,
    IDA_TGT_BANK = 3'b011,
    IDA_TGT_GPR = 3'b100,
    IDA_TGT_SFR = 3'b101
  } ida_tgt_t;

  typedef struct packed {
    logic [7:0] ptr_a;
    logic [7:0] ptr_b;
    logic [7:0] bank;
    logic [7:0] rdata;
    logic rvalid;
  } ida_state_t;

endpackage

// [rtl/ida_gpr_ram.sv]
`timescale 1ns/1ns
`include "ida_map.svh"

module ida_gpr_ram #(
  parameter int NUM_BANKS = 3,
  parameter int BANK_W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Access
  input wire logic wr_en,
  input wire logic [BANK_W-1:0] bank,
  input wire logic [6:0] offset,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  localparam int DEPTH = NUM_BANKS * `IDA_BANK_SIZE;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } ida_ram_state_t;

  ida_ram_state_t s_q;
  ida_ram_state_t s_d;
  logic [BANK_W+6:0] idx;

  generate
    if (NUM_BANKS < 1 || NUM_BANKS > (1 << BANK_W))
    begin : g_check
      $error("ida_gpr_ram: bank count does not fit the bank field");
    end
  endgenerate

  assign idx = {bank, offset};
  // Caller may pass a bank at or above NUM_BANKS; it then drops the write and ignores rdata
  assign rdata = s_q.mem[idx];

  always_comb
  begin
    s_d = s_q;
    if (wr_en)
    begin
      s_d.mem[idx] = wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

// [rtl/ida_top.sv]
// Notes on behaviour
// - Window addresses hold nothing; access goes to address in paired pointer.
// - First window and pointer always reach bank 0.
// - Second window and pointer reach the bank held in bank select.
// - Indirect read of a window address through a pointer returns 00h.
// - Indirect write of a window address through a pointer is discarded.
// - Both pointers are 8 bits, full in-bank address.
// - Pointers are real read/write storage usable by any register instruction.
// - Direct addressing always reaches bank 0 for general memory.
// - Special registers same in every bank; 40h exists only in bank 1.
// - Bank select low bits pick bank; 11 undefined; upper bits read zero.
// - Reset clears bank select, except watchdog reset during power-down.
`timescale 1ns/1ns
`include "ida_map.svh"

module ida_top #(
  parameter int NUM_BANKS = 3,
  parameter int BANK_W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // System reset event and its cause
  input wire logic sys_reset,
  input wire logic wdt_pd_reset,
  // Core data memory access
  input wire logic [7:0] core_addr,
  input wire logic core_rd,
  input wire logic core_wr,
  input wire logic [7:0] core_wdata,
  output logic [7:0] core_rdata,
  output logic core_rvalid,
  // Remaining special registers
  output logic [7:0] sfr_addr,
  output logic sfr_rd,
  output logic sfr_wr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);

  ida_pkg::ida_state_t s_q;
  ida_pkg::ida_state_t s_d;
  ida_pkg::ida_tgt_t tgt;
  logic win_a;
  logic win_b;
  logic [7:0] eff_addr;
  logic [BANK_W-1:0] eff_bank;
  logic [BANK_W-1:0] cur_bank;
  logic [7:0] sfr_bank;
  logic null_hit;
  logic bank_ok;
  logic ram_wr;
  logic [7:0] ram_rdata;

  generate
    if (NUM_BANKS < 1 || NUM_BANKS > (1 << BANK_W) || BANK_W > 8)
    begin : g_check
      $error("ida_top: bank count does not fit the bank field");
    end
  endgenerate

  assign cur_bank = s_q.bank[BANK_W-1:0];
  assign win_a = (core_addr == `IDA_OFF_WIN_A);
  assign win_b = (core_addr == `IDA_OFF_WIN_B);
  // Redirect through the paired pointer
  assign eff_addr = win_a ? s_q.ptr_a : (win_b ? s_q.ptr_b : core_addr);
  assign eff_bank = win_b ? cur_bank : '0;
  // Special-register decode sees the selected bank except via first window
  assign sfr_bank = win_a ? 8'h00 : s_q.bank;
  // Pointer naming a window address: nothing behind it
  assign null_hit = (win_a || win_b)
    && (eff_addr == `IDA_OFF_WIN_A || eff_addr == `IDA_OFF_WIN_B);
  assign bank_ok = int'(eff_bank) < NUM_BANKS;

  always_comb
  begin
    tgt = ida_pkg::IDA_TGT_NONE;
    if (null_hit)
    begin
      tgt = ida_pkg::IDA_TGT_NONE;
    end
    else if (eff_addr[`IDA_GPR_BIT])
    begin
      tgt = bank_ok ? ida_pkg::IDA_TGT_GPR : ida_pkg::IDA_TGT_NONE;
    end
    else if (eff_addr == `IDA_OFF_PTR_A)
    begin
      tgt = ida_pkg::IDA_TGT_PTR_A;
    end
    else if (eff_addr == `IDA_OFF_PTR_B)
    begin
      tgt = ida_pkg::IDA_TGT_PTR_B;
    end
    else if (eff_addr == `IDA_OFF_BANK)
    begin
      tgt = ida_pkg::IDA_TGT_BANK;
    end
    else if (eff_addr != `IDA_OFF_MEM_CTRL || sfr_bank == `IDA_MEM_CTRL_BANK)
    begin
      tgt = ida_pkg::IDA_TGT_SFR;
    end
  end

  assign ram_wr = core_wr && (tgt == ida_pkg::IDA_TGT_GPR);
  assign sfr_addr = eff_addr;
  assign sfr_rd = core_rd && (tgt == ida_pkg::IDA_TGT_SFR);
  assign sfr_wr = core_wr && (tgt == ida_pkg::IDA_TGT_SFR);
  assign sfr_wdata = core_wdata;

  // Bank above pointer forms the physical address
  ida_gpr_ram #(
    .NUM_BANKS(NUM_BANKS),
    .BANK_W(BANK_W)
  ) u_ram (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(ram_wr),
    .bank(eff_bank),
    .offset(eff_addr[6:0]),
    .wdata(core_wdata),
    .rdata(ram_rdata)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = core_rd;
    s_d.rdata = `IDA_NULL_READ;
    unique case (tgt)
      ida_pkg::IDA_TGT_NONE:
      begin
        s_d.rdata = `IDA_NULL_READ;
      end
      ida_pkg::IDA_TGT_PTR_A:
      begin
        s_d.rdata = s_q.ptr_a;
        if (core_wr)
        begin
          s_d.ptr_a = core_wdata;
        end
      end
      ida_pkg::IDA_TGT_PTR_B:
      begin
        s_d.rdata = s_q.ptr_b;
        if (core_wr)
        begin
          s_d.ptr_b = core_wdata;
        end
      end
      ida_pkg::IDA_TGT_BANK:
      begin
        s_d.rdata = s_q.bank;
        if (core_wr)
        begin
          s_d.bank = 8'h00;
          s_d.bank[BANK_W-1:0] = core_wdata[BANK_W-1:0];
        end
      end
      ida_pkg::IDA_TGT_GPR:
      begin
        s_d.rdata = ram_rdata;
      end
      ida_pkg::IDA_TGT_SFR:
      begin
        s_d.rdata = sfr_rdata;
      end
      default:
      begin
        s_d.rdata = `IDA_NULL_READ;
      end
    endcase
    if (!core_rd)
    begin
      s_d.rdata = s_q.rdata;
    end
    // Watchdog wake from power-down keeps the bank
    if (sys_reset && !wdt_pd_reset)
    begin
      s_d.bank = `IDA_BANK_RST;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q.ptr_a <= `IDA_PTR_RST;
      s_q.ptr_b <= `IDA_PTR_RST;
      s_q.bank <= `IDA_BANK_RST;
      s_q.rdata <= 8'h00;
      s_q.rvalid <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign core_rdata = s_q.rdata;
  assign core_rvalid = s_q.rvalid;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_ptr_a_write;
    core_wr && core_addr == `IDA_OFF_PTR_A;
  endsequence

  sequence s_ptr_a_readback;
    core_rd && core_addr == `IDA_OFF_PTR_A ##1 core_rvalid;
  endsequence

  a_win_redirect: assert property (
    core_rd && win_a && s_q.ptr_a[7] && !core_wr
    |-> ##1 core_rvalid && core_rdata == $past(ram_rdata))
    else $error("window read not taken from pointed memory");

  a_win_a_bank0: assert property (
    core_wr && win_a && s_q.ptr_a[7] |-> ram_wr && eff_bank == '0)
    else $error("first window left bank 0");

  a_win_b_bank: assert property (
    core_wr && win_b && s_q.ptr_b[7] && int'(cur_bank) < NUM_BANKS
    |-> ram_wr && {eff_bank, eff_addr[6:0]} == {cur_bank, s_q.ptr_b[6:0]})
    else $error("second window missed the selected bank");

  a_null_read: assert property (
    core_rd && null_hit |=> core_rvalid && core_rdata == `IDA_NULL_READ)
    else $error("window read through pointer not zero");

  a_null_write: assert property (
    core_wr && null_hit && !sys_reset
    |-> !ram_wr && !sfr_wr ##1 $stable(s_q.ptr_a) && $stable(s_q.ptr_b) && $stable(s_q.bank))
    else $error("window write through pointer changed state");

  a_ptr_storage: assert property (
    s_ptr_a_write ##1 (!core_wr)[*1] ##0 s_ptr_a_readback
    |-> core_rdata == $past(core_wdata, 2))
    else $error("pointer does not hold written byte");

  a_direct_bank0: assert property (
    core_wr && !win_a && !win_b && core_addr[7] |-> ram_wr && eff_bank == '0)
    else $error("direct access left bank 0");

  a_mem_ctrl_bank1: assert property (
    core_rd && core_addr == `IDA_OFF_MEM_CTRL |-> sfr_rd == (s_q.bank == `IDA_MEM_CTRL_BANK))
    else $error("memory-control register decode wrong");

  a_bank_upper_zero: assert property (
    core_rd && core_addr == `IDA_OFF_BANK |=> core_rdata[7:BANK_W] == '0)
    else $error("bank select upper bits not zero");

  a_bank_reset: assert property (
    sys_reset && !wdt_pd_reset |=> s_q.bank == `IDA_BANK_RST)
    else $error("bank select not cleared by reset");

  a_bank_kept_wdt: assert property (
    sys_reset && wdt_pd_reset && !core_wr |=> $stable(s_q.bank))
    else $error("bank select lost on watchdog wake");

endmodule

// [tb/ida_sfr_model.sv]
`timescale 1ns/1ns

module ida_sfr_model (
  // Clock
  input wire logic clk,
  // Special register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);
  logic [7:0] regs [0:127];
  logic [7:0] last_q = 8'h00;

  initial
  begin
    foreach (regs[i]) regs[i] = 8'h00;
  end

  always @(posedge clk)
  begin
    if (sfr_wr) regs[sfr_addr[6:0]] <= sfr_wdata;
    if (sfr_rd) last_q <= regs[sfr_addr[6:0]];
  end

  // Unselected bus shows the inverse of the last value
  assign sfr_rdata = sfr_rd ? regs[sfr_addr[6:0]] : ~last_q;
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ns

module tb_top;
  logic clk, reset_n, sys_reset, wdt_pd_reset, core_rd, core_wr, core_rvalid, sfr_rd, sfr_wr;
  logic [7:0] core_addr, core_wdata, core_rdata, sfr_addr, sfr_wdata, sfr_rdata;
  int n_errors = 0;
  int n_checks = 0;

  ida_top u_ida_top (.clk(clk), .reset_n(reset_n), .sys_reset(sys_reset),
    .wdt_pd_reset(wdt_pd_reset), .core_addr(core_addr), .core_rd(core_rd),
    .core_wr(core_wr), .core_wdata(core_wdata), .core_rdata(core_rdata),
    .core_rvalid(core_rvalid), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

  ida_sfr_model u_ida_sfr_model (.clk(clk), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core_addr = a;
    core_wdata = d;
    core_wr = 1'b1;
    @(posedge clk);
    #1;
    core_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Read, then check the one-cycle answer and its end
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    core_addr = a;
    core_rd = 1'b1;
    @(posedge clk);
    #1;
    chk("rvalid", 8'h01, {7'h00, core_rvalid});
    chk($sformatf("rdata at %h", a), exp, core_rdata);
    core_rd = 1'b0;
    @(posedge clk);
    #1;
    chk("rvalid end", 8'h00, {7'h00, core_rvalid});
  endtask

  // Write, then read the same address in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    core_addr = a;
    core_wdata = d;
    core_wr = 1'b1;
    @(posedge clk);
    #1;
    core_wr = 1'b0;
    core_rd = 1'b1;
    @(posedge clk);
    #1;
    chk("rvalid", 8'h01, {7'h00, core_rvalid});
    chk($sformatf("rdata after write at %h", a), exp, core_rdata);
    core_rd = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic sys_rst(input logic wdt);
    wdt_pd_reset = wdt;
    sys_reset = 1'b1;
    @(posedge clk);
    #1;
    sys_reset = 1'b0;
    @(posedge clk);
    #1;
  endtask

  initial
  begin
    #20000;
    n_errors++;
    summarize();
  end

  initial
  begin
    reset_n = 1'b0;
    sys_reset = 1'b0;
    wdt_pd_reset = 1'b0;
    core_addr = 8'h00;
    core_wdata = 8'h00;
    core_rd = 1'b0;
    core_wr = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h03, 8'hff);
    wr(8'h01, 8'hff);
    for (logic [7:0] b = 8'h00; b < 8'h03; b++)
    begin
      wr(8'h04, b);
      wr(8'h02, 8'h20 + b);
    end
    for (logic [7:0] b = 8'h00; b < 8'h04; b++)
    begin
      wr(8'h04, b);
      rd(8'h02, (b == 8'h03) ? 8'h00 : 8'h20 + b);
      rd(8'hff, 8'h20);
      rd(8'h00, 8'h20);
    end
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h03);
    wr(8'h04, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h77);
    rd(8'h00, 8'h00);
    wr(8'h03, 8'h02);
    wr(8'h02, 8'h77);
    rd(8'h02, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h02);
    // Fill four cells through window a, stepping the pointer
    wr(8'h01, 8'h90);
    for (logic [7:0] i = 8'h00; i < 8'h04; i++)
    begin
      wr(8'h00, 8'ha0 + i);
      rd(8'h01, 8'h90 + i);
      wr(8'h01, 8'h91 + i);
    end
    for (logic [7:0] i = 8'h00; i < 8'h04; i++)
      rd(8'h90 + i, 8'ha0 + i);
    wr_rd(8'h01, 8'h5a, 8'h5a);
    wr(8'h04, 8'h02);
    wr_rd(8'h94, 8'h3c, 8'h3c);
    wr(8'h03, 8'h94);
    rd(8'h02, 8'h00);
    for (logic [7:0] b = 8'h00; b < 8'h03; b++)
    begin
      wr(8'h04, b);
      wr(8'h10, 8'h5c + b);
      rd(8'h10, 8'h5c + b);
      rd(8'h40, 8'h00);
    end
    wr(8'h04, 8'h01);
    wr(8'h40, 8'h66);
    rd(8'h40, 8'h66);
    wr(8'h04, 8'h02);
    rd(8'h40, 8'h00);
    sys_rst(1'b1);
    rd(8'h04, 8'h02);
    sys_rst(1'b0);
    rd(8'h04, 8'h00);
    summarize();
  end
endmodule
